// File: rtl/scr_pkg.sv
// scr_pkg: register map, field positions, reset values and states
package scr_pkg;

  // ---------------------------------------------------------------
  // register byte offsets on the bus
  // ---------------------------------------------------------------
  localparam logic [7:0] SCR_OFS_CTRL = 8'h00;
  localparam logic [7:0] SCR_OFS_MODE = 8'h04;
  localparam logic [7:0] SCR_OFS_CARD = 8'h08;
  localparam logic [7:0] SCR_OFS_BAUD = 8'h0c;
  localparam logic [7:0] SCR_OFS_TXD = 8'h10;
  localparam logic [7:0] SCR_OFS_RXD = 8'h14;
  localparam logic [7:0] SCR_OFS_STAT = 8'h18;
  localparam logic [7:0] SCR_OFS_MASK = 8'h1c;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SCR_CTL_TIE = 7;
  localparam int SCR_CTL_RIE = 6;
  localparam int SCR_CTL_TE = 5;
  localparam int SCR_CTL_RE = 4;
  localparam int SCR_CTL_ADDR_FILTER_ENABLE = 3;
  localparam int SCR_CTL_TX_DONE_IRQ_ENABLE = 2;
  localparam int SCR_CTL_CKHI = 1;
  localparam int SCR_CTL_CKLO = 0;
  localparam int SCR_MODE_SYNC = 7;
  localparam int SCR_MODE_MP = 2;
  localparam int SCR_CARD_SEL = 0;
  localparam int SCR_ST_TXE = 0;
  localparam int SCR_ST_RXF = 1;
  localparam int SCR_ST_ERR = 2;
  localparam int SCR_ST_TEND = 3;
  localparam int SCR_ST_ORE = 4;
  localparam int SCR_ST_FER = 5;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SCR_CTRL_RST = 8'h00;
  localparam logic [7:0] SCR_MODE_RST = 8'h00;
  localparam logic [7:0] SCR_CARD_RST = 8'h00;
  localparam logic [7:0] SCR_BAUD_RST = 8'h00;
  localparam logic [3:0] SCR_MASK_RST = 4'h0;
  localparam logic [5:0] SCR_STAT_RST = 6'h00;
  localparam logic [8:0] SCR_DATA_RST = 9'h000;

  // ---------------------------------------------------------------
  // cycle counts: sixteen ticks to a bit, eight to a half bit
  // ---------------------------------------------------------------
  localparam logic [3:0] SCR_MID_TICK = 4'h7;
  localparam logic [3:0] SCR_LAST_TICK = 4'hf;
  localparam logic [2:0] SCR_HALF_LAST = 3'h7;
  localparam logic [2:0] SCR_LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    SCR_IDLE,
    SCR_START,
    SCR_DATA,
    SCR_MPB,
    SCR_STOP
  } scr_state_t;

endpackage : scr_pkg

// File: rtl/scr_sync.sv
// scr_sync: three-flop pin synchroniser with agreed-level edge pulses
`timescale 1ns/10ps
`default_nettype none

module scr_sync #(
  parameter logic INIT = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin and its cleaned view
  input wire logic pin_i,
  output logic lvl_o,
  output logic rise_o,
  output logic fall_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic chg;

  // a change counts only once the second and third stage agree
  assign chg = (s2_q == s3_q) && (s3_q != lvl_q);
  assign lvl_o = lvl_q;
  assign rise_o = chg & s3_q;
  assign fall_o = chg & ~s3_q;

  // shift chain; the first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {s1_q, s2_q, s3_q, lvl_q} <= {4{INIT}};
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (chg) lvl_q <= s3_q;
    end
  end

endmodule : scr_sync

`default_nettype wire

// File: rtl/scr_serial_unit.sv
// scr_serial_unit: serial unit with control register, engines, bus slave
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R01 - control bits act only with card mode off
// R02 - tx_irq_enable gates transmit-empty interrupt
// R03 - rx_irq_enable gates receive-full and error interrupts
// R04 - transmitter runs only while tx_enable set
// R05 - receiver runs only while rx_enable set
// R06 - address filter needs async and multiproc_format
// R07 - filtered frames with mp bit 0 dropped
// R08 - mp bit 1 frame clears filter, resumes
// R09 - tx_done_irq_enable gates transmit-end interrupt
// R10 - async 00: internal clock, pin released
// R11 - async 01: internal clock, bit-rate clock out
// R12 - async 1x: pin gives sixteen-times clock
// R13 - sync 0x: internal clock driven on pin
// R14 - sync 1x: shift on incoming pin clock
// R15 - all control bits read/write, reset zero
module scr_serial_unit
  import scr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial pins
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  // interrupt
  output logic irq_o
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d, mode_q, card_q, baud_q, bcnt_q;
  logic [3:0] mask_q;
  logic [5:0] stat_q, stat_set;
  logic [8:0] tdr_q, tx_sh_q, rdr_q, rx_sh_q, rx_sh_d;
  logic tdr_empty_q, rx_full_q, ack_q;
  logic [31:0] rdat_q, rd_word;
  scr_state_t tx_st_q, tx_st_d, rx_st_q, rx_st_d;
  logic [3:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
  logic [2:0] tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d, hc_q;
  logic tx_seen_q, tx_seen_d, txd_q, txd_d, sck_int_q;
  logic tx_end, rx_done, rx_stop_ok;
  logic rxd_lvl, sck_rise, sck_fall;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic req, wr, rd, wr_ctrl, wr_mode, wr_card, wr_baud, wr_txd;
  logic wr_stat, wr_mask, rd_rxd;
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign wr_ctrl = wr && (wb_adr_i == SCR_OFS_CTRL);
  assign wr_mode = wr && (wb_adr_i == SCR_OFS_MODE);
  assign wr_card = wr && (wb_adr_i == SCR_OFS_CARD);
  assign wr_baud = wr && (wb_adr_i == SCR_OFS_BAUD);
  assign wr_txd = wr && (wb_adr_i == SCR_OFS_TXD);
  assign wr_stat = wr && (wb_adr_i == SCR_OFS_STAT);
  assign wr_mask = wr && (wb_adr_i == SCR_OFS_MASK);
  assign rd_rxd = rd && (wb_adr_i == SCR_OFS_RXD);

  // read selection; unmapped offsets answer with zero
  assign rd_word =
    (wb_adr_i == SCR_OFS_CTRL) ? {24'h000000, ctrl_q} :
    (wb_adr_i == SCR_OFS_MODE) ? {24'h000000, mode_q} :
    (wb_adr_i == SCR_OFS_CARD) ? {24'h000000, card_q} :
    (wb_adr_i == SCR_OFS_BAUD) ? {24'h000000, baud_q} :
    (wb_adr_i == SCR_OFS_TXD) ? {23'h000000, tdr_q} :
    (wb_adr_i == SCR_OFS_RXD) ? {23'h000000, rdr_q} :
    (wb_adr_i == SCR_OFS_STAT) ?
      {24'h000000, rx_full_q, tdr_empty_q, stat_q} :
    (wb_adr_i == SCR_OFS_MASK) ? {28'h0000000, mask_q} : 32'h00000000;

  // ---------------------------------------------------------------
  // mode view of the control bits
  // ---------------------------------------------------------------
  logic normal, te, re, sync_mode, mp_fmt, ext_clk, filt;
  assign normal = ~card_q[SCR_CARD_SEL]; // R01
  assign te = ctrl_q[SCR_CTL_TE] & normal; // R04
  assign re = ctrl_q[SCR_CTL_RE] & normal; // R05
  assign sync_mode = mode_q[SCR_MODE_SYNC];
  assign mp_fmt = mode_q[SCR_MODE_MP];
  assign ext_clk = ctrl_q[SCR_CTL_CKHI];
  assign filt = ctrl_q[SCR_CTL_ADDR_FILTER_ENABLE] & mp_fmt & ~sync_mode; // R06

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  scr_sync #(.INIT(1'b1)) u_rxd_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(rxd_i),
    .lvl_o(rxd_lvl),
    .rise_o(),
    .fall_o()
  );

  scr_sync #(.INIT(1'b1)) u_sck_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(sck_i),
    .lvl_o(),
    .rise_o(sck_rise),
    .fall_o(sck_fall)
  );

  // ---------------------------------------------------------------
  // clock sources
  // ---------------------------------------------------------------
  logic baud_tick, tick16, sck_run, int_tgl, rise_ev, fall_ev;
  logic tx_bend, rx_bend, tx_load;
  assign baud_tick = (bcnt_q == baud_q);
  // async: pin rising edges replace the internal sixteen-times tick
  assign tick16 = ext_clk ? sck_rise : baud_tick; // R10 R11 R12
  // internal bit clock idles high; in sync mode it runs only for work
  assign sck_run = ~ext_clk & normal & (sync_mode ?
    ((tx_st_q != SCR_IDLE) | (re & ~rx_full_q)) :
    ctrl_q[SCR_CTL_CKLO]); // R11 R13
  assign int_tgl = sck_run & baud_tick & (hc_q == SCR_HALF_LAST);
  assign rise_ev = ext_clk ? sck_rise : (int_tgl & ~sck_int_q); // R14
  assign fall_ev = ext_clk ? sck_fall : (int_tgl & sck_int_q); // R14
  assign tx_bend = tick16 && (tx_cnt_q == SCR_LAST_TICK);
  assign rx_bend = tick16 && (rx_cnt_q == SCR_LAST_TICK);
  assign tx_load = te && (tx_st_q == SCR_IDLE) && !tdr_empty_q;

  // divider and internal pin clock; half period is eight ticks
  always_ff @(posedge clk_i) begin
    if (rst_i || baud_tick) bcnt_q <= 8'h00;
    else bcnt_q <= bcnt_q + 8'h01;
    if (rst_i || !sck_run) begin
      hc_q <= 3'h0;
      sck_int_q <= 1'b1;
    end else if (baud_tick) begin
      hc_q <= hc_q + 3'h1;
      if (int_tgl) sck_int_q <= ~sck_int_q;
    end
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tick16 ? tx_cnt_q + 4'h1 : tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_seen_d = tx_seen_q;
    txd_d = txd_q;
    tx_end = 1'b0;
    if (!te) begin
      tx_st_d = SCR_IDLE; // R04
      txd_d = 1'b1;
    end else begin
      unique case (tx_st_q)
        SCR_IDLE: begin
          if (tx_load) begin
            tx_cnt_d = 4'h0;
            tx_bit_d = 3'h0;
            tx_seen_d = 1'b0;
            tx_st_d = sync_mode ? SCR_DATA : SCR_START;
            txd_d = sync_mode ? tdr_q[0] : 1'b0;
          end
        end
        SCR_START: begin
          if (tx_bend) begin
            tx_st_d = SCR_DATA;
            txd_d = tx_sh_q[0];
          end
        end
        SCR_DATA: begin
          if (sync_mode) begin
            // first fall only opens the frame; shift on later ones
            if (fall_ev && tx_seen_q) begin
              tx_seen_d = 1'b0;
              tx_bit_d = tx_bit_q + 3'h1;
              txd_d = tx_sh_q[tx_bit_q + 3'h1];
            end
            if (rise_ev) begin
              tx_seen_d = 1'b1;
              if (tx_bit_q == SCR_LAST_BIT) begin
                tx_st_d = SCR_IDLE; // R14
                tx_end = 1'b1;
              end
            end
          end else if (tx_bend) begin
            tx_bit_d = tx_bit_q + 3'h1;
            if (tx_bit_q == SCR_LAST_BIT) begin
              tx_st_d = mp_fmt ? SCR_MPB : SCR_STOP;
              txd_d = mp_fmt ? tx_sh_q[8] : 1'b1;
            end else begin
              txd_d = tx_sh_q[tx_bit_q + 3'h1];
            end
          end
        end
        SCR_MPB: begin
          if (tx_bend) begin
            tx_st_d = SCR_STOP;
            txd_d = 1'b1;
          end
        end
        SCR_STOP: begin
          if (tx_bend) begin
            tx_st_d = SCR_IDLE;
            tx_end = 1'b1;
          end
        end
        default: tx_st_d = SCR_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = tick16 ? rx_cnt_q + 4'h1 : rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_done = 1'b0;
    rx_stop_ok = 1'b0;
    if (!re) begin
      rx_st_d = SCR_IDLE; // R05
    end else begin
      unique case (rx_st_q)
        SCR_IDLE: begin
          rx_sh_d[8] = 1'b0;
          rx_bit_d = 3'h0;
          rx_cnt_d = 4'h0;
          if (sync_mode) rx_st_d = SCR_DATA;
          else if (!rxd_lvl) rx_st_d = SCR_START;
        end
        SCR_START: begin
          // a start bit that is gone at mid-bit is taken for noise
          if (tick16 && rx_cnt_q == SCR_MID_TICK) begin
            rx_cnt_d = 4'h0;
            rx_st_d = rxd_lvl ? SCR_IDLE : SCR_DATA;
          end
        end
        SCR_DATA: begin
          if (sync_mode ? rise_ev : rx_bend) begin
            rx_sh_d[rx_bit_q] = rxd_lvl; // R14
            rx_bit_d = rx_bit_q + 3'h1;
            if (rx_bit_q == SCR_LAST_BIT) begin
              rx_done = sync_mode;
              rx_stop_ok = 1'b1;
              if (!sync_mode) rx_st_d = mp_fmt ? SCR_MPB : SCR_STOP;
            end
          end
        end
        SCR_MPB: begin
          if (rx_bend) begin
            rx_sh_d[8] = rxd_lvl;
            rx_st_d = SCR_STOP;
          end
        end
        SCR_STOP: begin
          if (rx_bend) begin
            rx_done = 1'b1;
            rx_stop_ok = rxd_lvl;
            rx_st_d = SCR_IDLE;
          end
        end
        default: rx_st_d = SCR_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // frame outcome and events
  // ---------------------------------------------------------------
  logic skip, wake, take, ore_ev, fer_ev, rxf_ev, tend_ev;
  assign skip = filt & ~rx_sh_d[8]; // R07
  assign wake = rx_done & filt & rx_sh_d[8]; // R08
  assign take = rx_done & ~skip; // R07
  assign ore_ev = take & rx_full_q;
  assign fer_ev = take & ~rx_full_q & ~rx_stop_ok;
  assign rxf_ev = take & ~rx_full_q & rx_stop_ok;
  assign tend_ev = tx_end & tdr_empty_q;

  // software write wins over the self-clear of the filter bit
  assign ctrl_d = wr_ctrl ? wb_dat_i[7:0] : // R15
    (wake ? (ctrl_q & ~(8'h01 << SCR_CTL_ADDR_FILTER_ENABLE)) : ctrl_q); // R08

  // request enables decide which events reach the four request bits; ORE and FER are ungated
  always_comb begin
    stat_set = 6'h00;
    stat_set[SCR_ST_TXE] = tx_load & ctrl_q[SCR_CTL_TIE]; // R02
    stat_set[SCR_ST_RXF] = rxf_ev & ctrl_q[SCR_CTL_RIE]; // R03
    stat_set[SCR_ST_ERR] = (ore_ev | fer_ev) & ctrl_q[SCR_CTL_RIE]; // R03
    stat_set[SCR_ST_TEND] = tend_ev & ctrl_q[SCR_CTL_TX_DONE_IRQ_ENABLE]; // R09
    stat_set[SCR_ST_ORE] = ore_ev;
    stat_set[SCR_ST_FER] = fer_ev;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= SCR_CTRL_RST; // R15
      mode_q <= SCR_MODE_RST;
      card_q <= SCR_CARD_RST;
      baud_q <= SCR_BAUD_RST;
      mask_q <= SCR_MASK_RST;
      stat_q <= SCR_STAT_RST;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_mode) mode_q <= wb_dat_i[7:0];
      if (wr_card) card_q <= wb_dat_i[7:0];
      if (wr_baud) baud_q <= wb_dat_i[7:0];
      if (wr_mask) mask_q <= wb_dat_i[3:0];
      // write one to clear; a new event in the same cycle wins
      stat_q <= (stat_q & ~(wr_stat ? wb_dat_i[5:0] : 6'h00)) | stat_set;
    end
  end

  // data holding registers and their flags; setting beats clearing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tdr_q <= SCR_DATA_RST;
      rdr_q <= SCR_DATA_RST;
      tdr_empty_q <= 1'b1;
      rx_full_q <= 1'b0;
    end else begin
      if (wr_txd) tdr_q <= {wb_dat_i[8] & wb_sel_i[1], wb_dat_i[7:0]};
      if (rxf_ev) rdr_q <= rx_sh_d;
      tdr_empty_q <= !te || tx_load || (tdr_empty_q && !wr_txd); // R04
      rx_full_q <= rxf_ev || (rx_full_q && !rd_rxd);
    end
  end

  // engine state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_q <= SCR_IDLE;
      rx_st_q <= SCR_IDLE;
      {tx_cnt_q, rx_cnt_q, tx_bit_q, rx_bit_q} <= 14'h0000;
      {tx_seen_q, txd_q} <= 2'b01;
      tx_sh_q <= SCR_DATA_RST;
      rx_sh_q <= SCR_DATA_RST;
    end else begin
      tx_st_q <= tx_st_d;
      rx_st_q <= rx_st_d;
      {tx_cnt_q, rx_cnt_q, tx_bit_q, rx_bit_q} <=
        {tx_cnt_d, rx_cnt_d, tx_bit_d, rx_bit_d};
      {tx_seen_q, txd_q} <= {tx_seen_d, txd_d};
      if (tx_load) tx_sh_q <= tdr_q;
      rx_sh_q <= rx_sh_d;
    end
  end

  // bus answer: one cycle after the request, then dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      if (rd) rdat_q <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign txd_o = txd_q;
  assign sck_o = sck_int_q;
  // pin released for port use in async 00 and for every input clock
  assign sck_oe_o = normal & ~ext_clk &
    (sync_mode | ctrl_q[SCR_CTL_CKLO]); // R10 R11 R12 R13
  assign irq_o = |(stat_q[3:0] & mask_q);

endmodule : scr_serial_unit

`default_nettype wire

// File: dv/scr_chk_asserts.sv
// scr_chk_asserts: port-level checker for the serial unit
`timescale 1ns/10ps
`default_nettype none

module scr_chk
  import scr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins
  input wire logic txd_o,
  input wire logic sck_oe_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------
  // shadow copies of what software wrote
  // ----------------------------------------------------------
  logic [7:0] ctl_q, mod_q, crd_q, bau_q;
  logic [3:0] msk_q;
  logic tke;
  logic wr;
  assign tke = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = tke && wb_we_i && wb_sel_i[0];

  // bit 3 may self-clear in hardware, so it is never compared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {ctl_q, mod_q, crd_q, bau_q, msk_q} <= '0;
    end else if (wr) begin
      case (wb_adr_i)
        SCR_OFS_CTRL: ctl_q <= wb_dat_i[7:0];
        SCR_OFS_MODE: mod_q <= wb_dat_i[7:0];
        SCR_OFS_CARD: crd_q <= wb_dat_i[7:0];
        SCR_OFS_BAUD: bau_q <= wb_dat_i[7:0];
        SCR_OFS_MASK: msk_q <= wb_dat_i[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  sequence s_rd_ctl;
    tke && !wb_we_i && wb_adr_i == SCR_OFS_CTRL;
  endsequence
  sequence s_rd_gap;
    tke && !wb_we_i && wb_adr_i >= 8'h20;
  endsequence
  property p_ack;
    tke |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  property p_ctl_rb;
    s_rd_ctl ##1 wb_ack_o |-> wb_dat_o == {24'h0, ctl_q & 8'hf7}
      || wb_dat_o == {24'h0, ctl_q | 8'h08};
  endproperty
  property p_gap;
    s_rd_gap ##1 wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  property p_rst;
    $fell(rst_i) |-> txd_o && !irq_o && !sck_oe_o;
  endproperty
  property p_oe_async;
    !mod_q[7] && !crd_q[0] |-> sck_oe_o == (ctl_q[1:0] == 2'b01);
  endproperty
  property p_oe_sync;
    mod_q[7] && !crd_q[0] |-> sck_oe_o == !ctl_q[1];
  endproperty
  property p_card;
    crd_q[0] |-> !sck_oe_o;
  endproperty
  property p_tx_off;
    !ctl_q[5] && !$past(ctl_q[5]) |-> txd_o;
  endproperty
  property p_tx_bit;
    $fell(txd_o) && bau_q == 8'h00 && !mod_q[7] |-> !txd_o [*8];
  endproperty
  property p_mask;
    msk_q == 4'h0 |-> !irq_o;
  endproperty

  a_ack: assert property (p_ack) else $error("ack not one cycle");
  a_ctl_rb: assert property (p_ctl_rb) else $error("ctrl readback");
  a_gap: assert property (p_gap) else $error("unmapped read data");
  a_rst: assert property (p_rst) else $error("pins after reset");
  a_oe_async: assert property (p_oe_async) else $error("oe");
  a_oe_sync: assert property (p_oe_sync) else $error("sync oe");
  a_card: assert property (p_card) else $error("card mode oe");
  a_tx_off: assert property (p_tx_off) else $error("tx while off");
  a_tx_bit: assert property (p_tx_bit) else $error("short bit");
  a_mask: assert property (p_mask) else $error("irq masked");
endmodule : scr_chk

bind scr_serial_unit scr_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd_o(txd_o),
  .sck_oe_o(sck_oe_o), .irq_o(irq_o));

`default_nettype wire

// File: dv/scr_peer.sv
// scr_peer: remote serial device on the data and clock lines
`timescale 1ns/10ps
`default_nettype none

module scr_peer (
  // clock
  input wire logic clk_i,
  // lines facing the device
  input wire logic txd_i,
  output logic rxd_o,
  output logic sck_o
);
  logic run_q = 1'b0;

  initial rxd_o = 1'b1;
  initial sck_o = 1'b1;

  // 16x clock, 200 ns, stands high between frames
  always #100 sck_o = run_q ? ~sck_o : 1'b1;

  // send one frame, bt clock cycles per bit, nb data bits
  task automatic send(input logic [8:0] d, input int nb,
                      input logic stp, input int bt);
    logic [10:0] f;
    f = (nb == 9) ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
    for (int i = 0; i < nb + 2; i++) begin
      rxd_o <= f[i];
      repeat (bt) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask : send

  // sample a frame at bit centres; ok low on timeout or bad stop
  task automatic catch(output logic [7:0] d, output bit ok,
                       input int bt);
    int n;
    n = 0;
    ok = 1'b0;
    d = 8'h00;
    while (txd_i !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n < 4000) begin
      repeat (bt / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bt) @(posedge clk_i);
        d[i] = txd_i;
      end
      repeat (bt) @(posedge clk_i);
      ok = (txd_i === 1'b1);
    end
  endtask : catch
endmodule : scr_peer

`default_nettype wire

// File: dv/testbench.sv
// testbench: drives the serial unit over the bus and the peer
`timescale 1ns/10ps
`default_nettype none

module testbench
  import scr_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic ack, txd, rxd, sck, sck_o, sck_oe, irq;
  int n_errors = 0;
  int num_checks = 0;

  always #12.5 clk_i = ~clk_i;

  scr_serial_unit i_scr_serial_unit (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .rxd_i(rxd), .txd_o(txd), .sck_i(sck), .sck_o(sck_o),
    .sck_oe_o(sck_oe), .irq_o(irq));
  scr_peer i_scr_peer (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd),
    .sck_o(sck));

  // ----------------------------------------------------------
  // reporting and bus access
  // ----------------------------------------------------------
  task close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  // single classic cycle; request held until ack is sampled
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      n_errors++;
      close_out();
    end
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task rc(input string nm, input logic [7:0] a, input logic [31:0] m,
          input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q & m);
  endtask : rc

  // txd stays high 200 cycles; sck_o shows ne edges
  task quiet(input string nm, input int ne);
    int z, e;
    logic p;
    z = 0;
    e = 0;
    p = sck_o;
    repeat (200) begin
      @(posedge clk_i);
      z += (txd !== 1'b1);
      e += (sck_o !== p);
      p = sck_o;
    end
    chk(nm, 0, z);
    chk(nm, ne, e);
  endtask : quiet

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task t_regs;
    rc("ctl_rst", SCR_OFS_CTRL, 32'hffffffff, 32'h0);
    wr(SCR_OFS_CTRL, 32'ha5);
    rc("ctl_a5", SCR_OFS_CTRL, 32'hffffffff, 32'ha5);
    wr(SCR_OFS_CTRL, 32'h5a);
    rc("ctl_5a", SCR_OFS_CTRL, 32'hffffffff, 32'h5a);
    wr(SCR_OFS_CTRL, 32'h0);
    rc("gap", 8'h20, 32'hffffffff, 32'h0);
  endtask : t_regs

  task t_clk;
    for (int m = 0; m < 2; m++) begin
      wr(SCR_OFS_MODE, m ? 32'h80 : 32'h0);
      for (int c = 0; c < 4; c++) begin
        wr(SCR_OFS_CTRL, c);
        chk("sck_oe", m ? (c < 2) : (c == 1), sck_oe);
      end
    end
    wr(SCR_OFS_MODE, 32'h0);
  endtask : t_clk

  // first pass raises tx-empty only, second tx-end only
  task t_tx;
    logic [7:0] d;
    bit ok;
    wr(SCR_OFS_BAUD, 32'h0);
    wr(SCR_OFS_MASK, 32'hf);
    for (int k = 0; k < 2; k++) begin
      wr(SCR_OFS_STAT, 32'hff);
      wr(SCR_OFS_CTRL, k ? 32'h24 : 32'ha0);
      fork
        i_scr_peer.catch(d, ok, 16);
        wr(SCR_OFS_TXD, k ? 32'ha5 : 32'h5a);
      join
      repeat (40) @(posedge clk_i);
      chk("tx_data", k ? 8'ha5 : 8'h5a, d);
      chk("tx_stop", 1, ok);
      rc("tx_ev", SCR_OFS_STAT, 32'hf, k ? 32'h8 : 32'h1);
      chk("tx_irq", 1, irq);
    end
    wr(SCR_OFS_MASK, 32'h0);
    chk("irq_mask", 0, irq);
    wr(SCR_OFS_MASK, 32'hf);
    chk("irq_unmask", 1, irq);
    wr(SCR_OFS_STAT, 32'h8);
    chk("irq_clr", 0, irq);
  endtask : t_tx

  task t_off;
    wr(SCR_OFS_CARD, 32'h1);
    wr(SCR_OFS_CTRL, 32'h21);
    chk("card_oe", 0, sck_oe);
    wr(SCR_OFS_TXD, 32'h0);
    quiet("card_tx", 0);
    wr(SCR_OFS_CARD, 32'h0);
    wr(SCR_OFS_CTRL, 32'h01);
    wr(SCR_OFS_TXD, 32'h0);
    quiet("te_off", 25);
  endtask : t_off

  task t_rx;
    wr(SCR_OFS_STAT, 32'hff);
    wr(SCR_OFS_MASK, 32'h6);
    wr(SCR_OFS_CTRL, 32'h50);
    i_scr_peer.send(9'h0c3, 8, 1'b1, 16);
    repeat (30) @(posedge clk_i);
    chk("rx_irq", 1, irq);
    rc("rx_data", SCR_OFS_RXD, 32'hff, 32'hc3);
    wr(SCR_OFS_STAT, 32'hff);
    i_scr_peer.send(9'h03c, 8, 1'b0, 16);
    repeat (30) @(posedge clk_i);
    rc("rx_err", SCR_OFS_STAT, 32'h26, 32'h24);
    chk("err_irq", 1, irq);
    wr(SCR_OFS_STAT, 32'hff);
    wr(SCR_OFS_CTRL, 32'h40);
    i_scr_peer.send(9'h0c3, 8, 1'b1, 16);
    repeat (30) @(posedge clk_i);
    rc("rx_off", SCR_OFS_STAT, 32'h82, 32'h0);
  endtask : t_rx

  task t_mp;
    wr(SCR_OFS_MODE, 32'h04);
    wr(SCR_OFS_CTRL, 32'h18);
    i_scr_peer.send(9'h011, 9, 1'b1, 16);
    repeat (30) @(posedge clk_i);
    rc("mp_skip", SCR_OFS_STAT, 32'hb2, 32'h0);
    rc("mp_hold", SCR_OFS_CTRL, 32'h08, 32'h08);
    i_scr_peer.send(9'h122, 9, 1'b1, 16);
    repeat (30) @(posedge clk_i);
    rc("mp_clr", SCR_OFS_CTRL, 32'h08, 32'h0);
    rc("mp_data", SCR_OFS_RXD, 32'h1ff, 32'h122);
    wr(SCR_OFS_MODE, 32'h0);
    wr(SCR_OFS_CTRL, 32'h18);
    i_scr_peer.send(9'h044, 8, 1'b1, 16);
    repeat (30) @(posedge clk_i);
    rc("mp_off", SCR_OFS_RXD, 32'hff, 32'h44);
  endtask : t_mp

  // peer clock gives 16 ticks a bit: 128 system cycles
  task t_ext;
    logic [7:0] d;
    bit ok;
    wr(SCR_OFS_CTRL, 32'h22);
    i_scr_peer.run_q = 1'b1;
    chk("ext_oe", 0, sck_oe);
    fork
      i_scr_peer.catch(d, ok, 128);
      wr(SCR_OFS_TXD, 32'h96);
    join
    i_scr_peer.run_q = 1'b0;
    chk("ext_data", 8'h96, d);
    chk("ext_stop", 1, ok);
  endtask : t_ext

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_clk();
    t_tx();
    t_off();
    t_rx();
    t_mp();
    t_ext();
    close_out();
  end
endmodule : testbench

`default_nettype wire
